// *** tmcs_top.sv ***
// Thermal monitor control, status, scheduling and link request logic
//
// Behaviour
// (R01) Arbitration loser keeps alert, gives no acknowledge
// (R02) Alert latch clears only on won response
// (R03) Command index resets to zero
// (R04) Standby one-shot runs one conversion, then stops
// (R05) Idle one-shot starts conversion, restarts rate timer
// (R06) One-shot during running conversion is ignored
// (R07) Config bit 7 suppresses all alert assertion
// (R08) Config bit 6 halts conversion, enters standby
// (R09) Config bit 5 enables fan failure detection
// (R10) Config bit 4 enables shutdown, else low
// (R11) Fault queue field plus one, reset three
// (R12) Status flags sticky until read or reset
// (R13) Status read leaves alert latch alone
// (R14) Status byte bit layout busy alarms open fan
// (R15) Status bit 1 always reads zero
// (R16) Rate codes 0 to 7 double rate
// (R17) Started conversions finish within 156 ms
// (R18) Rate timer results follow new rate interval
// (R19) Host reads one-shot status after completion
// (R20) Host checks collisions or stops converter first
// (R21) Host rereads status when low seven ones
// (R22) Alert on reaching high or low limit
// (R23) Shutdown after queued consecutive critical conversions
// (R24) Only three rate bits decoded, reset 02h
// (R25) Index loaded, then byte read or write
`timescale 1ns/1ps
module tmcs_top #(
    parameter int SLOW_CYC = tmcs_pkg::SLOW_INTERVAL_CYCLES,
    parameter int CONV_MAX = tmcs_pkg::CONV_MAX_CYCLES
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 link_clk,
    input  wire logic                 link_rst,
    input  wire logic                 lk_req_valid,
    input  wire tmcs_pkg::tmcs_req_s  lk_req,
    output logic                      lk_req_ready,
    output logic                      lk_rsp_valid,
    output logic [7:0]                lk_rsp_data,
    output logic                      conv_start,
    output logic                      conv_busy,
    input  wire logic                 adc_done,
    input  wire logic [1:0][7:0]      ch_result,
    input  wire logic                 diode_open,
    input  wire logic                 fan_fail,
    input  wire logic [1:0][7:0]      upper_alarm_limit,
    input  wire logic [1:0][7:0]      lower_alarm_limit,
    input  wire logic [1:0][7:0]      crit_limit,
    output logic [1:0][7:0]           remote_temp_result,
    output logic [7:0]                thermal_status,
    output logic                      alert_out,
    output logic                      alert_oe,
    output logic                      shutdown_output
);
    // Link domain: holds one request until the core answers
    tmcs_pkg::tmcs_req_s req_hold;
    logic                req_tgl;
    logic                lk_busy;
    logic [2:0]          ack_sync;
    logic                ack_tgl;
    logic [7:0]          rsp_word;
    wire                 ack_evt = ack_sync[2] ^ ack_sync[1];

    assign lk_req_ready = !lk_busy;

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            req_hold     <= '0;
            req_tgl      <= 1'b0;
            lk_busy      <= 1'b0;
            ack_sync     <= 3'h0;
            lk_rsp_valid <= 1'b0;
            lk_rsp_data  <= 8'h00;
        end else begin
            ack_sync     <= {ack_sync[1:0], ack_tgl};
            lk_rsp_valid <= ack_evt;
            if (ack_evt) begin
                lk_busy     <= 1'b0;
                lk_rsp_data <= rsp_word;
            end
            if (lk_req_valid && !lk_busy) begin
                req_hold <= lk_req;
                req_tgl  <= ~req_tgl;
                lk_busy  <= 1'b1;
            end
        end
    end

    // Core domain: request event from toggle crossing
    logic [2:0] req_sync;
    wire        req_evt = req_sync[2] ^ req_sync[1];

    always_ff @(posedge core_clk) begin
        if (rst) req_sync <= 3'h0;
        else     req_sync <= {req_sync[1:0], req_tgl};
    end

    logic [7:0]           cmd_index;
    logic [7:0]           cfg;
    logic [7:0]           rate;
    logic [7:0]           flags;
    logic                 alert_latch;
    tmcs_pkg::tmcs_conv_e state;
    logic [31:0]          rate_cnt;
    logic [31:0]          conv_cnt;
    logic                 start_pending;
    logic                 stby_q;
    logic                 open_cond;
    logic [1:0]           hi_cond;
    logic [1:0]           lo_cond;
    logic [1:0]           hit_hi;
    logic [1:0]           hit_lo;
    logic [1:0]           crit_trip;

    wire is_cmd  = req_evt && req_hold.kind == tmcs_pkg::REQ_CMD;
    wire is_wr   = req_evt && req_hold.kind == tmcs_pkg::REQ_WRITE;
    wire is_rd   = req_evt && req_hold.kind == tmcs_pkg::REQ_READ;
    wire is_ara  = req_evt && req_hold.kind == tmcs_pkg::REQ_ARA;
    wire oneshot = is_cmd && req_hold.data == tmcs_pkg::IDX_ONE_SHOT;
    wire wr_cfg  = is_wr && cmd_index == tmcs_pkg::IDX_WR_CFG;
    wire wr_rate = is_wr && cmd_index == tmcs_pkg::IDX_WR_RATE;
    wire rd_stat = is_rd && cmd_index == tmcs_pkg::IDX_STATUS;
    wire ara_win = is_ara && req_hold.data[0];

    wire standby  = cfg[tmcs_pkg::CFG_STBY_BIT];
    wire mask     = cfg[tmcs_pkg::CFG_MASK_BIT];
    wire fan_en   = cfg[tmcs_pkg::CFG_FAN_BIT];
    wire shdn_en  = cfg[tmcs_pkg::CFG_SHDN_BIT];
    wire busy     = state == tmcs_pkg::CONV_RUN;
    wire stby_in  = standby && !stby_q;
    wire wake     = stby_q && !standby;

    // Interval halves per code step; slowest code 0
    wire [2:0]  rate_code = rate[tmcs_pkg::RATE_CODE_W-1:0];  // [R24]
    wire [31:0] interval  = 32'(SLOW_CYC) >> rate_code;  // [R16] [R18]
    wire        rate_due  = rate_cnt >= interval - 32'h1;

    wire conv_end = busy && !stby_in &&
                    (adc_done || conv_cnt >= 32'(CONV_MAX - 1));  // [R17]
    wire start_evt = !busy && !stby_in &&
                     (oneshot || (!standby && (start_pending || rate_due)));  // [R04] [R05]

    // Command index and configuration writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cmd_index <= tmcs_pkg::IDX_RESET;  // [R03]
            cfg       <= tmcs_pkg::CFG_RESET;  // [R10] [R11]
            rate      <= tmcs_pkg::RATE_RESET;  // [R24]
            stby_q    <= 1'b0;
        end else begin
            stby_q <= standby;
            if (is_cmd) cmd_index <= req_hold.data;  // [R25]
            if (wr_cfg) cfg <= req_hold.data;
            if (wr_rate) rate <= req_hold.data;
        end
    end

    // Read selection by index
    wire [7:0] rd_table [0:8];
    assign rd_table[0] = remote_temp_result[1];
    assign rd_table[1] = remote_temp_result[0];
    assign rd_table[2] = thermal_status;
    assign rd_table[3] = cfg;
    assign rd_table[4] = rate;
    assign rd_table[5] = upper_alarm_limit[1];
    assign rd_table[6] = lower_alarm_limit[1];
    assign rd_table[7] = upper_alarm_limit[0];
    assign rd_table[8] = lower_alarm_limit[0];
    wire [7:0] rd_mux = (cmd_index <= tmcs_pkg::IDX_RD_LO1) ? rd_table[cmd_index[3:0]] : 8'h00;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_tgl  <= 1'b0;
            rsp_word <= 8'h00;
        end else if (req_evt) begin
            ack_tgl  <= ~ack_tgl;
            rsp_word <= is_rd ? rd_mux : 8'h00;  // [R25]
        end
    end

    // Conversion scheduler
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state         <= tmcs_pkg::CONV_IDLE;
            start_pending <= 1'b1;
            conv_cnt      <= 32'h0;
            rate_cnt      <= 32'h0;
            conv_start    <= 1'b0;
        end else begin
            conv_start <= start_evt;
            if (stby_in) begin
                state         <= tmcs_pkg::CONV_IDLE;  // [R08]
                start_pending <= 1'b0;
            end else if (start_evt) begin
                state         <= tmcs_pkg::CONV_RUN;
                start_pending <= 1'b0;
            end else if (conv_end) begin
                state <= tmcs_pkg::CONV_IDLE;  // [R04]
            end else if (wake) begin
                start_pending <= 1'b1;
            end
            if (start_evt) conv_cnt <= 32'h0;
            else if (busy) conv_cnt <= conv_cnt + 32'h1;  // [R06]
            if (start_evt) rate_cnt <= 32'h0;  // [R05]
            else if (!rate_due) rate_cnt <= rate_cnt + 32'h1;
        end
    end

    assign conv_busy = busy;

    // Per channel limit compare and shutdown fault queue
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            logic [4:0] crit_cnt;
            wire hit_crit = $signed(ch_result[g]) >= $signed(crit_limit[g]);
            assign hit_hi[g] = $signed(ch_result[g]) >= $signed(upper_alarm_limit[g]);  // [R22]
            assign hit_lo[g] = $signed(ch_result[g]) <= $signed(lower_alarm_limit[g]);  // [R22]
            assign crit_trip[g] = crit_cnt > {1'b0, cfg[3:0]};  // [R11] [R23]
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    crit_cnt              <= 5'h0;
                    hi_cond[g]            <= 1'b0;
                    lo_cond[g]            <= 1'b0;
                    remote_temp_result[g] <= 8'h00;
                end else if (conv_end) begin
                    hi_cond[g]            <= hit_hi[g];
                    lo_cond[g]            <= hit_lo[g];
                    remote_temp_result[g] <= ch_result[g];
                    if (!hit_crit) crit_cnt <= 5'h0;  // [R23]
                    else if (crit_cnt != tmcs_pkg::CRIT_CNT_MAX) crit_cnt <= crit_cnt + 5'h1;
                end
            end
        end
    endgenerate

    // Sticky status flags, set wins over read clear
    wire       open_set = start_evt && diode_open;
    wire       fan_cond = fan_fail && fan_en;  // [R09]
    wire [7:0] set_vec  = {1'b0, conv_end & hit_hi[1], conv_end & hit_lo[1],
                           conv_end & hit_hi[0], conv_end & hit_lo[0],
                           open_set, 1'b0, fan_cond};
    wire [7:0] cond_vec = {1'b0, hi_cond[1], lo_cond[1], hi_cond[0], lo_cond[0],
                           open_cond, 1'b0, fan_cond};
    wire [7:0] next_flags = (set_vec | (rd_stat ? cond_vec : flags))
                            & tmcs_pkg::STICKY_MASK;  // [R12] [R15]
    wire       alert_set  = |set_vec && !mask;  // [R07] [R22]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags       <= 8'h00;
            open_cond   <= 1'b0;
            alert_latch <= 1'b0;
            shutdown_output <= 1'b0;
        end else begin
            flags <= next_flags;  // [R12]
            if (start_evt) open_cond <= diode_open;
            alert_latch <= alert_set || (alert_latch && !ara_win);  // [R01] [R02] [R13]
            shutdown_output <= shdn_en && |crit_trip;  // [R10] [R23]
        end
    end

    assign thermal_status = {busy, flags[6:2], 1'b0, flags[0]};  // [R14] [R15]
    assign alert_out = 1'b0;
    assign alert_oe  = alert_latch;  // [R01]

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_index_reset: assert property (disable iff (1'b0)
        rst |=> cmd_index == 8'h00)  // [R03]
        else $error("command index not zero after reset");
    chk_alert_clear: assert property ($fell(alert_latch) |-> $past(ara_win))  // [R02]
        else $error("alert latch cleared without won response");
    chk_alert_lose: assert property (alert_latch && is_ara && !ara_win |=> alert_latch)  // [R01]
        else $error("arbitration loser released alert");
    chk_alert_mask: assert property (mask && !alert_latch |=> !alert_latch)  // [R07]
        else $error("alert asserted while masked");
    chk_standby_halt: assert property ($rose(standby) |=> !busy)  // [R08]
        else $error("conversion not halted by standby");
    chk_standby_once: assert property (standby && conv_end |=> !busy ##1 (busy -> $past(oneshot)))  // [R04]
        else $error("standby started an extra conversion");
    chk_oneshot_idle: assert property (!busy && oneshot && !stby_in |=> busy && rate_cnt == 32'h0)  // [R05]
        else $error("idle one-shot did not start and restart timer");
    chk_oneshot_busy: assert property (busy && oneshot && !conv_end && !stby_in
        |=> busy && conv_cnt == $past(conv_cnt) + 32'h1)  // [R06]
        else $error("one-shot disturbed running conversion");
    chk_shutdown_off: assert property (!shdn_en |=> !shutdown_output)  // [R10]
        else $error("shutdown driven while disabled");
    chk_status_sticky: assert property (flags[4] && !rd_stat |=> flags[4])  // [R12]
        else $error("sticky flag dropped without read");
    chk_status_alert: assert property (rd_stat && alert_latch && !ara_win |=> alert_latch)  // [R13]
        else $error("status read cleared alert latch");
    chk_conv_bound: assert property (busy |-> conv_cnt < 32'(CONV_MAX))  // [R17]
        else $error("conversion exceeded its bound");
    chk_status_rsvd: assert property (thermal_status[1] == 1'b0 ##1 thermal_status[1] == 1'b0)  // [R15]
        else $error("reserved status bit set");
endmodule : tmcs_top

// *** tmcs_pkg.sv ***
// Constants and types for the thermal monitor control and status block
package tmcs_pkg;
    localparam int CLK_PERIOD_NS    = 100;
    localparam int SLOW_INTERVAL_MS = 16000;
    localparam int CONV_MAX_MS      = 156;
    localparam int SLOW_INTERVAL_CYCLES = SLOW_INTERVAL_MS * (1000000 / CLK_PERIOD_NS);
    localparam int CONV_MAX_CYCLES      = CONV_MAX_MS * (1000000 / CLK_PERIOD_NS);

    localparam logic [7:0] IDX_RESET    = 8'h00;
    localparam logic [7:0] IDX_TEMP2    = 8'h00;
    localparam logic [7:0] IDX_TEMP1    = 8'h01;
    localparam logic [7:0] IDX_STATUS   = 8'h02;
    localparam logic [7:0] IDX_RD_CFG   = 8'h03;
    localparam logic [7:0] IDX_RD_RATE  = 8'h04;
    localparam logic [7:0] IDX_RD_HI2   = 8'h05;
    localparam logic [7:0] IDX_RD_LO2   = 8'h06;
    localparam logic [7:0] IDX_RD_HI1   = 8'h07;
    localparam logic [7:0] IDX_RD_LO1   = 8'h08;
    localparam logic [7:0] IDX_WR_CFG   = 8'h09;
    localparam logic [7:0] IDX_WR_RATE  = 8'h0a;
    localparam logic [7:0] IDX_ONE_SHOT = 8'h0f;

    localparam logic [7:0] CFG_RESET    = 8'h12;
    localparam logic [7:0] RATE_RESET   = 8'h02;
    localparam logic [7:0] STICKY_MASK  = 8'h7d;
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STBY_BIT = 6;
    localparam int CFG_FAN_BIT  = 5;
    localparam int CFG_SHDN_BIT = 4;
    localparam int RATE_CODE_W  = 3;
    localparam logic [4:0] CRIT_CNT_MAX = 5'h10;

    typedef enum logic [1:0] {
        REQ_CMD   = 2'b00,
        REQ_WRITE = 2'b01,
        REQ_READ  = 2'b10,
        REQ_ARA   = 2'b11
    } tmcs_req_e;

    typedef struct packed {
        tmcs_req_e  kind;
        logic [7:0] data;
    } tmcs_req_s;

    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } tmcs_conv_e;
endpackage : tmcs_pkg

// *** tmcs_host_model.sv ***
// Link-side host model issuing index, byte and alert-response requests
`timescale 1ns/1ps
module tmcs_host_model (
    input  wire logic           link_clk,
    input  wire logic           lk_req_ready,
    input  wire logic           lk_rsp_valid,
    input  wire logic [7:0]     lk_rsp_data,
    output logic                lk_req_valid,
    output tmcs_pkg::tmcs_req_s lk_req
);
    initial begin
        lk_req_valid = 1'b0;
        lk_req       = '0;
    end

    // Held until taken, then answer awaited; data inverted once released
    task automatic xfer(input tmcs_pkg::tmcs_req_e kind, input logic [7:0] data,
                        output logic [7:0] rd);
        int n;
        n = 0;
        @(posedge link_clk);
        lk_req_valid <= 1'b1;
        lk_req       <= '{kind, data};
        do @(posedge link_clk); while (!lk_req_ready && ++n < 50);
        lk_req_valid <= 1'b0;
        lk_req.data  <= ~data;
        do @(posedge link_clk); while (!lk_rsp_valid && ++n < 100);
        rd = lk_rsp_data;
    endtask : xfer

    // Status read, repeated while the low seven bits are all ones
    task automatic read_status(output logic [7:0] rd);
        logic [7:0] d;
        int         n;
        n = 0;
        xfer(tmcs_pkg::REQ_CMD, tmcs_pkg::IDX_STATUS, d);
        do xfer(tmcs_pkg::REQ_READ, 8'h00, rd); while (rd[6:0] == 7'h7f && ++n < 4);
    endtask : read_status
endmodule : tmcs_host_model

// *** tb_thermal_monitor_control_status.sv ***
// Bench for the thermal monitor control and status block
`timescale 1ns/1ps
module tb_thermal_monitor_control_status;
    localparam int SLOW = 1024;
    logic                core_clk = 1'b0;
    logic                link_clk = 1'b0;
    logic                rst      = 1'b1;
    logic                link_rst = 1'b1;
    logic                lk_req_valid, lk_req_ready, lk_rsp_valid;
    tmcs_pkg::tmcs_req_s lk_req;
    logic [7:0]          lk_rsp_data, thermal_status, rd;
    logic                conv_start, conv_busy, alert_out, alert_oe, shutdown_output;
    logic                adc_done   = 1'b0;
    logic                stall      = 1'b0;
    logic                diode_open = 1'b0;
    logic                fan_fail   = 1'b0;
    logic [1:0][7:0]     ch_result  = {8'h19, 8'h05};
    logic [1:0][7:0]     up_lim     = {8'h50, 8'h50};
    logic [1:0][7:0]     lo_lim     = {8'hc9, 8'hc9};
    logic [1:0][7:0]     cr_lim     = {8'h60, 8'h60};
    logic [1:0][7:0]     remote_temp_result;
    logic [4:0]          dly        = 5'h00;
    int                  starts = 0, since = 0, gap = 0, fails = 0, checks_done = 0;

    always #50 core_clk = ~core_clk;
    initial begin
        #37;
        forever #80 link_clk = ~link_clk;
    end

    // Converter stand-in: done six cycles after each start unless stalled; start spacing kept
    always @(posedge core_clk) begin
        dly      <= {dly[3:0], conv_start};
        adc_done <= dly[4] && !stall;
        since    <= conv_start ? 1 : since + 1;
        if (conv_start) begin
            starts <= starts + 1;
            gap    <= since;
        end
    end

    tmcs_top #(.SLOW_CYC(SLOW), .CONV_MAX(200)) tmcs_top_i (
        .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
        .lk_req_valid(lk_req_valid), .lk_req(lk_req), .lk_req_ready(lk_req_ready),
        .lk_rsp_valid(lk_rsp_valid), .lk_rsp_data(lk_rsp_data),
        .conv_start(conv_start), .conv_busy(conv_busy), .adc_done(adc_done),
        .ch_result(ch_result), .diode_open(diode_open), .fan_fail(fan_fail),
        .upper_alarm_limit(up_lim), .lower_alarm_limit(lo_lim), .crit_limit(cr_lim),
        .remote_temp_result(remote_temp_result), .thermal_status(thermal_status),
        .alert_out(alert_out), .alert_oe(alert_oe), .shutdown_output(shutdown_output));

    tmcs_host_model tmcs_host_model_i (
        .link_clk(link_clk), .lk_req_ready(lk_req_ready), .lk_rsp_valid(lk_rsp_valid),
        .lk_rsp_data(lk_rsp_data), .lk_req_valid(lk_req_valid), .lk_req(lk_req));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    task automatic xf(input tmcs_pkg::tmcs_req_e k, input logic [7:0] d, output logic [7:0] r);
        tmcs_host_model_i.xfer(k, d, r);
    endtask : xf

    task automatic rdi(input logic [7:0] idx, output logic [7:0] v);
        xf(tmcs_pkg::REQ_CMD, idx, v);
        xf(tmcs_pkg::REQ_READ, 8'h00, v);
    endtask : rdi

    task automatic wri(input logic [7:0] idx, input logic [7:0] v);
        logic [7:0] d;
        xf(tmcs_pkg::REQ_CMD, idx, d);
        xf(tmcs_pkg::REQ_WRITE, v, d);
    endtask : wri

    // One-shot, then wait out the conversion before any status read
    task automatic shot();
        logic [7:0] d;
        xf(tmcs_pkg::REQ_CMD, 8'h0f, d);
        cyc(40);
    endtask : shot

    task automatic next_start();
        int s;
        int n;
        s = starts;
        n = 0;
        while (starts == s && n++ < 3000)
            cyc(1);
    endtask : next_start

    task automatic t_reset();
        cyc(40);
        xf(tmcs_pkg::REQ_READ, 8'h00, rd);
        check(rd, 8'h19);
        rdi(8'h03, rd);
        check(rd, 8'h12);
        rdi(8'h04, rd);
        check(rd, 8'h02);
    endtask : t_reset

    task automatic t_standby();
        int n;
        wri(8'h09, 8'h40);
        cyc(20);
        n = starts;
        cyc(600);
        check(8'(starts), 8'(n));
        shot();
        check(8'(starts), 8'(n + 1));
        cyc(600);
        check(8'(starts), 8'(n + 1));
        check({7'h0, conv_busy}, 8'h00);
        // Converter held off so the second one-shot lands mid-conversion
        stall <= 1'b1;
        shot();
        xf(tmcs_pkg::REQ_CMD, 8'h0f, rd);
        cyc(200);
        check(8'(starts), 8'(n + 2));
        check({7'h0, conv_busy}, 8'h00);
        stall <= 1'b0;
    endtask : t_standby

    task automatic t_status();
        cyc(1);
        ch_result  <= {8'h00, 8'h55};
        diode_open <= 1'b1;
        shot();
        tmcs_host_model_i.read_status(rd);
        check(rd, 8'h14);
        check({7'h0, alert_oe}, 8'h01);
        cyc(1);
        ch_result  <= 16'h0000;
        diode_open <= 1'b0;
        shot();
        tmcs_host_model_i.read_status(rd);
        check(rd & 8'h10, 8'h10);
        tmcs_host_model_i.read_status(rd);
        check(rd, 8'h00);
        check({7'h0, alert_oe}, 8'h01);
        xf(tmcs_pkg::REQ_ARA, 8'h00, rd);
        check({7'h0, alert_oe}, 8'h01);
        check({7'h0, alert_out}, 8'h00);
        xf(tmcs_pkg::REQ_ARA, 8'h01, rd);
        cyc(5);
        check({7'h0, alert_oe}, 8'h00);
    endtask : t_status

    task automatic t_mask_fan();
        wri(8'h09, 8'hc0);
        cyc(1);
        ch_result <= {8'h00, 8'h55};
        fan_fail  <= 1'b1;
        shot();
        check({7'h0, alert_oe}, 8'h00);
        tmcs_host_model_i.read_status(rd);
        check(rd & 8'h01, 8'h00);
        wri(8'h09, 8'h60);
        cyc(10);
        tmcs_host_model_i.read_status(rd);
        check(rd & 8'h01, 8'h01);
        fan_fail <= 1'b0;
    endtask : t_mask_fan

    task automatic t_shutdown();
        wri(8'h09, 8'h51);
        cyc(1);
        ch_result <= {8'h00, 8'h65};
        shot();
        check({7'h0, shutdown_output}, 8'h00);
        shot();
        check({7'h0, shutdown_output}, 8'h01);
        wri(8'h09, 8'h41);
        cyc(5);
        check({7'h0, shutdown_output}, 8'h00);
    endtask : t_shutdown

    task automatic t_rate();
        int n;
        wri(8'h09, 8'h00);
        for (int c = 7; c >= 0; c--) begin
            wri(8'h0a, 8'(c));
            next_start();
            next_start();
            check(8'(gap >= (SLOW >> c) - 2 && gap <= (SLOW >> c) + 2), 8'h01);
        end
        cyc(200);
        n = starts;
        xf(tmcs_pkg::REQ_CMD, 8'h0f, rd);
        if (starts == n)
            next_start();
        next_start();
        check(8'(gap >= SLOW - 2 && gap <= SLOW + 2), 8'h01);
    endtask : t_rate

    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge link_clk);
        link_rst <= 1'b0;
        t_reset();
        t_standby();
        t_status();
        t_mask_fan();
        t_shutdown();
        t_rate();
        results();
    end

    initial begin
        #5000000;
        fails++;
        results();
    end
endmodule : tb_thermal_monitor_control_status
